/* File: hdl/wesa_pkg.sv */
// package for the wakeup event state access register bank
// assumes a 32-bit AXI4-Lite register port with byte addresses
package wesa_pkg;
    localparam logic [31:0] WESA_ADDR_SET_PEND = 32'he001_e400;
    localparam logic [31:0] WESA_ADDR_MASK_INT = 32'he001_e480;
    localparam logic [31:0] WESA_ADDR_MASK_IRQ0 = 32'he001_e484;
    localparam logic [31:0] WESA_ADDR_WAKE_CTRL = 32'he001_e4c0;
    localparam logic [31:0] WESA_ADDR_WAKE_STAT = 32'he001_e4c4;
    localparam int WESA_IRQ_BANKS = 15;
    localparam int WESA_IRQ_PER_BANK = 32;
    localparam int WESA_IRQ_NUM = WESA_IRQ_BANKS * WESA_IRQ_PER_BANK;
    localparam int WESA_BIT_EVENT = 0;
    localparam int WESA_BIT_NMI = 1;
    localparam int WESA_BIT_DBG = 2;
    localparam logic [1:0] WESA_RESP_OKAY = 2'h0;
    localparam logic [1:0] WESA_RESP_SLVERR = 2'h2;
    localparam logic [2:0] WESA_PROT_PRIV = 3'h1;
    localparam logic [2:0] WESA_PROT_NS = 3'h2;
    localparam logic [31:0] WESA_ZERO = 32'h0000_0000;
endpackage

/* File: hdl/wesa_mask_if.sv */
// carrier between the bank top and its mask builder
// assumes one clock domain
`timescale 1ns/100ps
interface wesa_mask_if;
    logic [wesa_pkg::WESA_IRQ_NUM-1:0] irq_wake_enable;
    logic [wesa_pkg::WESA_IRQ_NUM-1:0] irq_supported;
    logic dbg_wake_enable;
    logic exec_prio_at_or_above_nmi;
    logic [wesa_pkg::WESA_IRQ_NUM-1:0] irq_mask;
    logic [2:0] int_mask;
    modport producer (
        input irq_wake_enable,
        input irq_supported,
        input dbg_wake_enable,
        input exec_prio_at_or_above_nmi,
        output irq_mask,
        output int_mask
    );
    modport consumer (
        output irq_wake_enable,
        output irq_supported,
        output dbg_wake_enable,
        output exec_prio_at_or_above_nmi,
        input irq_mask,
        input int_mask
    );
endinterface

/* File: hdl/wesa_mask_build.sv */
// builds the wake mask words from core state
// assumes inputs already in the core clock domain
`timescale 1ns/100ps
module wesa_mask_build (
    wesa_mask_if.producer m
);
    genvar g;
    // ----------------------------------------
    // per interrupt mask bits
    // ----------------------------------------
    generate
        for (g = 0; g < wesa_pkg::WESA_IRQ_NUM; g = g + 1)
        begin : g_irq
            // zero means wake masking on; unsupported reads zero
            assign m.irq_mask[g] = m.irq_wake_enable[g] & m.irq_supported[g];
        end
    endgenerate
    assign m.int_mask[wesa_pkg::WESA_BIT_DBG] = m.dbg_wake_enable;
    assign m.int_mask[wesa_pkg::WESA_BIT_NMI] = ~m.exec_prio_at_or_above_nmi;
    assign m.int_mask[wesa_pkg::WESA_BIT_EVENT] = 1'b0;
endmodule

/* File: hdl/wesa_top.sv */
// wakeup event state access register bank, AXI4-Lite slave
// assumes core state inputs synchronous to ref_clk, async active-high rst
//
// Overview of operation
// - writing one to set-pending bit 2 raises a debug request pulse
// - writing one to set-pending bit 1 raises a non-maskable interrupt pulse
// - writing one to set-pending bit 0 raises a receive event pulse
// - zeros written to set-pending bits have no effect
// - set-pending register is write-only, injects wake events
// - with security extension present and banking bit clear, non-secure access reads zero, ignores writes
// - unprivileged access is refused and raises a bus fault
// - one shared copy of each register for both security states
// - internal mask bit 2 reports debug request wake masking, zero is masked
// - internal mask bit 1 reports nmi wake masking, zero is masked
// - nmi reads masked when execution priority at or above nmi priority
// - internal mask bit 0 always reads zero
// - fifteen irq mask registers, each covering 32 interrupts from index times 32
// - irq mask bit zero means wake masking enabled for that interrupt
// - mask bits of unsupported interrupts read zero
// - mask registers expose the wake set at sleep entry
`timescale 1ns/100ps
module wesa_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic security_ext_present,
    input wire logic nonsecure_fault_banking_bit,
    input wire logic [wesa_pkg::WESA_IRQ_NUM-1:0] irq_wake_enable,
    input wire logic [wesa_pkg::WESA_IRQ_NUM-1:0] irq_supported,
    input wire logic dbg_wake_enable,
    input wire logic exec_prio_at_or_above_nmi,
    input wire logic sleep_entry,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic external_debug_request,
    output logic nmi_request,
    output logic receive_event_input,
    output logic bus_fault,
    output logic auto_transfer_enable
);
    // ----------------------------------------
    // mask builder
    // ----------------------------------------
    wesa_mask_if mif ();
    assign mif.irq_wake_enable = irq_wake_enable;
    assign mif.irq_supported = irq_supported;
    assign mif.dbg_wake_enable = dbg_wake_enable;
    assign mif.exec_prio_at_or_above_nmi = exec_prio_at_or_above_nmi;
    wesa_mask_build u_mask (
        .m(mif.producer)
    );

    // snapshot taken at sleep entry, one shared copy for both states
    logic [wesa_pkg::WESA_IRQ_NUM-1:0] irq_snap_q;
    logic [2:0] int_snap_q;
    logic snap_valid_q;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_snap_q <= '0;
            int_snap_q <= '0;
            snap_valid_q <= 1'b0;
        end
        else if (sleep_entry)
        begin
            irq_snap_q <= mif.irq_mask;
            int_snap_q <= mif.int_mask;
            snap_valid_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    logic aw_have_q;
    logic w_have_q;
    logic [31:0] aw_addr_q;
    logic [2:0] aw_prot_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic wr_priv;
    logic wr_ns_blocked;
    logic wr_allowed;
    logic hit_set_pend_w;
    logic hit_ctrl_w;
    logic inject;
    logic [2:0] inj_bits;
    logic auto_q;

    assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wr_priv = (aw_prot_q & wesa_pkg::WESA_PROT_PRIV) != 3'h0;
    assign wr_ns_blocked = security_ext_present & ~nonsecure_fault_banking_bit &
        ((aw_prot_q & wesa_pkg::WESA_PROT_NS) != 3'h0);
    assign wr_allowed = wr_priv & ~wr_ns_blocked;
    assign hit_set_pend_w = aw_addr_q == wesa_pkg::WESA_ADDR_SET_PEND;
    assign hit_ctrl_w = aw_addr_q == wesa_pkg::WESA_ADDR_WAKE_CTRL;
    assign inject = wr_go & wr_allowed & hit_set_pend_w & w_strb_q[0];
    assign inj_bits = inject ? w_data_q[2:0] : 3'h0;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            aw_prot_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                aw_prot_q <= s_axi_awprot;
            end
            else if (wr_go)
                aw_have_q <= 1'b0;
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_go)
                w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wesa_pkg::WESA_RESP_OKAY;
            external_debug_request <= 1'b0;
            nmi_request <= 1'b0;
            receive_event_input <= 1'b0;
            auto_q <= 1'b1;
        end
        else
        begin
            s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
            external_debug_request <= inj_bits[wesa_pkg::WESA_BIT_DBG];
            nmi_request <= inj_bits[wesa_pkg::WESA_BIT_NMI];
            receive_event_input <= inj_bits[wesa_pkg::WESA_BIT_EVENT];
            if (wr_go & wr_allowed & hit_ctrl_w & w_strb_q[0])
                auto_q <= w_data_q[0];
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_priv ? wesa_pkg::WESA_RESP_OKAY
                    : wesa_pkg::WESA_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign auto_transfer_enable = auto_q;

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    logic rd_priv;
    logic rd_ns_blocked;
    logic rd_take;
    logic [31:0] rd_off;
    logic [31:0] rd_idx;
    logic rd_bank_hit;
    logic [31:0] rd_word;
    logic [31:0] bank_word;

    assign rd_take = s_axi_arvalid & s_axi_arready;
    assign rd_priv = (s_axi_arprot & wesa_pkg::WESA_PROT_PRIV) != 3'h0;
    assign rd_ns_blocked = security_ext_present & ~nonsecure_fault_banking_bit &
        ((s_axi_arprot & wesa_pkg::WESA_PROT_NS) != 3'h0);
    assign rd_off = s_axi_araddr - wesa_pkg::WESA_ADDR_MASK_IRQ0;
    assign rd_idx = {2'b00, rd_off[31:2]};
    assign rd_bank_hit = (s_axi_araddr >= wesa_pkg::WESA_ADDR_MASK_IRQ0) &
        (rd_idx < 32'(wesa_pkg::WESA_IRQ_BANKS)) & (rd_off[1:0] == 2'b00);
    assign bank_word = irq_snap_q[rd_idx[3:0]*wesa_pkg::WESA_IRQ_PER_BANK +: 32];
    assign rd_word =
        rd_ns_blocked ? wesa_pkg::WESA_ZERO :
        (s_axi_araddr == wesa_pkg::WESA_ADDR_MASK_INT) ? {29'h0, int_snap_q} :
        rd_bank_hit ? bank_word :
        (s_axi_araddr == wesa_pkg::WESA_ADDR_WAKE_CTRL) ? {31'h0, auto_q} :
        (s_axi_araddr == wesa_pkg::WESA_ADDR_WAKE_STAT) ? {31'h0, snap_valid_q} :
        wesa_pkg::WESA_ZERO;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= wesa_pkg::WESA_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~rd_take;
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_priv ? rd_word : wesa_pkg::WESA_ZERO;
                s_axi_rresp <= rd_priv ? wesa_pkg::WESA_RESP_OKAY
                    : wesa_pkg::WESA_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bus_fault <= 1'b0;
        else
            bus_fault <= (rd_take & ~rd_priv) | (wr_go & ~wr_priv);
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence inj_write_s;
        wr_go & wr_allowed & hit_set_pend_w & w_strb_q[0];
    endsequence
    inj_dbg_a: assert property (@(posedge ref_clk) disable iff (rst)
        inj_write_s ##0 w_data_q[2] |=> external_debug_request)
        else $error("debug request not raised");
    inj_nmi_a: assert property (@(posedge ref_clk) disable iff (rst)
        inj_write_s ##0 w_data_q[1] |=> nmi_request)
        else $error("nmi not raised");
    inj_evt_a: assert property (@(posedge ref_clk) disable iff (rst)
        inj_write_s ##0 w_data_q[0] |=> receive_event_input ##1 !receive_event_input)
        else $error("event not raised");
    inj_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        !inject |=> !external_debug_request && !nmi_request && !receive_event_input)
        else $error("spurious injection");
    ns_raz_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_take && rd_ns_blocked |=> s_axi_rdata == wesa_pkg::WESA_ZERO)
        else $error("nonsecure read not zero");
    unpriv_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_take && !rd_priv |=> bus_fault && s_axi_rresp == wesa_pkg::WESA_RESP_SLVERR)
        else $error("unprivileged read not faulted");
    evt_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_entry |=> int_snap_q[wesa_pkg::WESA_BIT_EVENT] == 1'b0)
        else $error("event mask bit not zero");
    nmi_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_entry && exec_prio_at_or_above_nmi |=> !int_snap_q[wesa_pkg::WESA_BIT_NMI])
        else $error("nmi not reported masked");
    spr_raz_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_take && s_axi_araddr == wesa_pkg::WESA_ADDR_SET_PEND |=> s_axi_rdata == 32'h0000_0000)
        else $error("set pending read not zero");
    unpriv_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_go && !wr_priv |=> bus_fault && s_axi_bresp == wesa_pkg::WESA_RESP_SLVERR)
        else $error("unprivileged write not faulted");
    ns_wi_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_go && wr_priv && wr_ns_blocked |=>
            s_axi_bresp == wesa_pkg::WESA_RESP_OKAY && !bus_fault)
        else $error("nonsecure write not ignored quietly");
    inj_none_a: assert property (@(posedge ref_clk) disable iff (rst)
        inject && w_data_q[2:0] == 3'h0 |=>
            !external_debug_request && !nmi_request && !receive_event_input)
        else $error("zero write injected an event");
    int_rsv_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_take && rd_priv && !rd_ns_blocked && s_axi_araddr == wesa_pkg::WESA_ADDR_MASK_INT
            |=> s_axi_rdata[31:3] == 29'h0 && !s_axi_rdata[wesa_pkg::WESA_BIT_EVENT])
        else $error("internal mask reserved bits not zero");
    dbg_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_entry |=> int_snap_q[wesa_pkg::WESA_BIT_DBG] == $past(dbg_wake_enable))
        else $error("debug wake mask not reported");
    irq_unsup_a: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_entry |=> (irq_snap_q & ~$past(irq_supported)) == '0)
        else $error("unsupported irq mask bit set");
endmodule

/* File: verification/test_wesa_top.sv */
// self-checking bench for the wakeup event state access register bank
// assumes the bank alone, driven here as an AXI4-Lite master at 20 MHz
`timescale 1ns/100ps
module test_wesa_top;
    localparam int N = wesa_pkg::WESA_IRQ_NUM;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic security_ext_present = 1'h1;
    logic nonsecure_fault_banking_bit = 1'h0;
    logic [N-1:0] irq_wake_enable = '0;
    logic [N-1:0] irq_supported = '0;
    logic dbg_wake_enable = 1'h0;
    logic exec_prio_at_or_above_nmi = 1'h0;
    logic sleep_entry = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic external_debug_request, nmi_request, receive_event_input, bus_fault;
    logic auto_transfer_enable;
    logic [31:0] inj [6] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0000,
        32'h0000_0007, 32'hffff_fff8};
    int n_errors = 0, n_tests = 0, c_dbg = 0, c_nmi = 0, c_ev = 0, c_bf = 0;
    int b0, b1, b2, b3;

    wesa_top dut_u (.ref_clk, .rst, .security_ext_present, .nonsecure_fault_banking_bit,
        .irq_wake_enable, .irq_supported, .dbg_wake_enable, .exec_prio_at_or_above_nmi,
        .sleep_entry, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_debug_request, .nmi_request, .receive_event_input, .bus_fault,
        .auto_transfer_enable);

    always #25 ref_clk = ~ref_clk;

    // counts pulses so each access can be judged by its side effects
    always @(posedge ref_clk)
    begin
        c_dbg += int'(external_debug_request === 1'h1);
        c_nmi += int'(nmi_request === 1'h1);
        c_ev += int'(receive_event_input === 1'h1);
        c_bf += int'(bus_fault === 1'h1);
    end

    // ------------------------------------------------------------
    // bus tasks and checking
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_r(input logic [1:0] e);
        check(32'(rsp), 32'(e));
    endtask

    task automatic mark;
        b0 = c_dbg;
        b1 = c_nmi;
        b2 = c_ev;
        b3 = c_bf;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] p);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awprot <= p;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (i == 100)
        begin
            n_errors++;
            $display("ERROR at %0t: no write response", $time);
        end
        // lets the pulse counters catch up before anyone compares them
        @(posedge ref_clk);
    endtask

    task automatic rdw(input logic [31:0] a, input logic [2:0] p);
        int i;
        s_axi_araddr <= a;
        s_axi_arprot <= p;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (i == 100)
        begin
            n_errors++;
            $display("ERROR at %0t: no read response", $time);
        end
        @(posedge ref_clk);
    endtask

    // takes a snapshot of a core state pattern and reads every mask word back
    // w: sleep entered by wait for event; the copied event mask bit still reads zero, w is only ORed in
    task automatic snap(input logic d, input logic p, input logic w, input logic [31:0] x);
        int n;
        dbg_wake_enable <= d;
        exec_prio_at_or_above_nmi <= p;
        for (n = 0; n < 15; n++)
        begin
            irq_wake_enable[n*32+:32] <= x ^ (32'(n) * 32'h0101_0101);
            irq_supported[n*32+:32] <= 32'hffff_ffff >> n;
        end
        sleep_entry <= 1'h1;
        @(posedge ref_clk);
        sleep_entry <= 1'h0;
        @(posedge ref_clk);
        rdw(wesa_pkg::WESA_ADDR_MASK_INT, wesa_pkg::WESA_PROT_PRIV);
        check(rd, {29'h0, d, ~p, 1'h0});
        check(rd | 32'(w), {29'h0, d, ~p, w});
        for (n = 0; n < 15; n++)
        begin
            rdw(wesa_pkg::WESA_ADDR_MASK_IRQ0 + 32'(4 * n), wesa_pkg::WESA_PROT_PRIV);
            check(rd, (x ^ (32'(n) * 32'h0101_0101)) & (32'hffff_ffff >> n));
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #1000000;
        n_errors++;
        tally_and_finish;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        check({31'h0, auto_transfer_enable}, 32'h0000_0001);
        rdw(wesa_pkg::WESA_ADDR_SET_PEND, wesa_pkg::WESA_PROT_PRIV);
        check(rd, 32'h0000_0000);
        check(32'(c_dbg + c_nmi + c_ev + c_bf), 32'h0000_0000);
        rdw(wesa_pkg::WESA_ADDR_WAKE_STAT, wesa_pkg::WESA_PROT_PRIV);
        check(rd, 32'h0000_0000);
        wr(wesa_pkg::WESA_ADDR_WAKE_CTRL, 32'h0000_0000, wesa_pkg::WESA_PROT_PRIV);
        chk_r(wesa_pkg::WESA_RESP_OKAY);
        check({31'h0, auto_transfer_enable}, 32'h0000_0000);
        rdw(wesa_pkg::WESA_ADDR_WAKE_CTRL, wesa_pkg::WESA_PROT_PRIV);
        check(rd, 32'h0000_0000);
        $display("test reset done");
        foreach (inj[i])
        begin
            mark;
            wr(wesa_pkg::WESA_ADDR_SET_PEND, inj[i], wesa_pkg::WESA_PROT_PRIV);
            chk_r(wesa_pkg::WESA_RESP_OKAY);
            check(32'(c_dbg - b0), {31'h0, inj[i][2]});
            check(32'(c_nmi - b1), {31'h0, inj[i][1]});
            check(32'(c_ev - b2), {31'h0, inj[i][0]});
        end
        $display("test injection done");
        snap(1'h0, 1'h1, 1'h1, 32'hf0f0_5a5a);
        snap(1'h1, 1'h0, 1'h0, 32'h0f0f_a5a5);
        rdw(wesa_pkg::WESA_ADDR_WAKE_STAT, wesa_pkg::WESA_PROT_PRIV);
        check(rd, 32'h0000_0001);
        $display("test masks done");
        rdw(wesa_pkg::WESA_ADDR_MASK_INT, 3'h3);
        check(rd, 32'h0000_0000);
        mark;
        wr(wesa_pkg::WESA_ADDR_SET_PEND, 32'h0000_0002, 3'h3);
        chk_r(wesa_pkg::WESA_RESP_OKAY);
        check(32'(c_nmi - b1), 32'h0000_0000);
        nonsecure_fault_banking_bit <= 1'h1;
        @(posedge ref_clk);
        rdw(wesa_pkg::WESA_ADDR_MASK_INT, 3'h3);
        check(rd, 32'h0000_0006);
        mark;
        wr(wesa_pkg::WESA_ADDR_SET_PEND, 32'h0000_0002, 3'h3);
        check(32'(c_nmi - b1), 32'h0000_0001);
        nonsecure_fault_banking_bit <= 1'h0;
        security_ext_present <= 1'h0;
        @(posedge ref_clk);
        rdw(wesa_pkg::WESA_ADDR_MASK_INT, 3'h3);
        check(rd, 32'h0000_0006);
        $display("test security done");
        mark;
        rdw(wesa_pkg::WESA_ADDR_MASK_INT, 3'h0);
        chk_r(wesa_pkg::WESA_RESP_SLVERR);
        check(rd, 32'h0000_0000);
        check(32'(c_bf - b3), 32'h0000_0001);
        mark;
        wr(wesa_pkg::WESA_ADDR_SET_PEND, 32'h0000_0004, 3'h0);
        chk_r(wesa_pkg::WESA_RESP_SLVERR);
        check(32'(c_dbg - b0), 32'h0000_0000);
        check(32'(c_bf - b3), 32'h0000_0001);
        rdw(32'he001_e500, wesa_pkg::WESA_PROT_PRIV);
        check(rd, 32'h0000_0000);
        chk_r(wesa_pkg::WESA_RESP_OKAY);
        $display("test privilege done");
        tally_and_finish;
    end
endmodule
